// file: verilog/frt_capture_pkg.sv
// constants, register map and bus carriers of the free-running timer with edge capture
package frt_capture_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_COUNTER_LOW   = 6'h20;
	localparam logic [5:0] IDX_COUNTER_HIGH  = 6'h21;
	localparam logic [5:0] IDX_CAP0_RISE     = 6'h22;
	localparam logic [5:0] IDX_CAP1_RISE     = 6'h23;
	localparam logic [5:0] IDX_CAP0_FALL     = 6'h24;
	localparam logic [5:0] IDX_CAP1_FALL     = 6'h25;
	localparam logic [5:0] IDX_TIMER_CONFIG  = 6'h2A;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int         CFG_HOLD_BIT      = 7;
	localparam int         CFG_PRESCALE_LSB  = 4;
	localparam int         CFG_PRESCALE_MSB  = 6;
	localparam int         CFG_WIDE_BIT      = 3;
	localparam logic [7:0] CFG_WRITE_MASK    = 8'hF8;
	localparam logic [7:0] CFG_RESET         = 8'h00;
	localparam logic [7:0] BYTE_RESET        = 8'h00;
	localparam logic [15:0] COUNTER_RESET    = 16'h0000;
	localparam int         NUM_CAPTURES      = 4;
	localparam int         CAP0_RISE         = 0;
	localparam int         CAP1_RISE         = 1;
	localparam int         CAP0_FALL         = 2;
	localparam int         CAP1_FALL         = 3;

	// ----------------------------------------------------------------
	// timing: timer tick divider (core_clk cycles per tick)
	// ----------------------------------------------------------------
	localparam int         TICK_DIV_DEFAULT  = 1;

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_lite_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axi_lite_rsp_t;

endpackage : frt_capture_pkg

// file: verilog/capture_edge_detect.sv
// two-stage synchroniser and edge detector for one capture input
`timescale 1ns/1ps
`default_nettype none

module capture_edge_detect (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic async_in,
	output logic      rise,
	output logic      fall
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// ----------------------------------------------------------------
	// synchroniser and previous sample
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign rise = sync_ff & ~prev_ff;
	assign fall = ~sync_ff & prev_ff;

endmodule : capture_edge_detect

`default_nettype wire

// file: verilog/capture_slot.sv
// one capture register with first-edge hold
`timescale 1ns/1ps
`default_nettype none

module capture_slot (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       hold_en,
	input  wire logic       capture_stb,
	input  wire logic [7:0] capture_value,
	input  wire logic       wr_stb,
	input  wire logic [7:0] wr_value,
	input  wire logic       rd_stb,
	output logic      [7:0] value_ff
);

	logic full_ff;
	logic accept;

	// held value is released by the read in the same cycle, so an edge then is kept
	assign accept = capture_stb & (~hold_en | ~full_ff | rd_stb);

	// ----------------------------------------------------------------
	// held flag
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			full_ff <= 1'b0;
		end else if (!hold_en) begin
			full_ff <= 1'b0;
		end else if (accept) begin
			full_ff <= 1'b1;
		end else if (rd_stb) begin
			full_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// stored value
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			value_ff <= frt_capture_pkg::BYTE_RESET;
		end else if (accept) begin
			value_ff <= capture_value;
		end else if (wr_stb) begin
			value_ff <= wr_value;
		end
	end

endmodule : capture_slot

`default_nettype wire

// file: verilog/free_running_timer_edge_capture.sv
// free-running 16-bit timer with edge capture behind an AXI4-Lite slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module free_running_timer_edge_capture #(
	parameter int unsigned TICK_DIV = frt_capture_pkg::TICK_DIV_DEFAULT
) (
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	input  wire frt_capture_pkg::axi_lite_req_t axi_req,
	output var frt_capture_pkg::axi_lite_rsp_t  axi_rsp,
	input  wire logic                           capture_input_0,
	input  wire logic                           capture_input_1
);

	localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic        aw_held_ff;
	logic [7:0]  awaddr_ff;
	logic        w_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        awready;
	logic        wready;
	logic        arready;
	logic        wr_fire;
	logic        wr_ok;
	logic        rd_fire;
	logic        wr_counter_low;
	logic        wr_counter_high;
	logic        wr_config;
	logic        rd_counter_low;
	logic [1:0]  wr_resp;
	logic [1:0]  rd_resp;
	logic [5:0]  wr_idx;
	logic [5:0]  rd_idx;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;
	logic [15:0] div_ff;
	logic        tick;
	logic [15:0] counter_ff;
	logic [7:0]  low_wr_hold_ff;
	logic [7:0]  high_rd_hold_ff;
	logic [7:0]  config_ff;
	logic        hold_en;
	logic        wide_capture_enable;
	logic [2:0]  prescale;
	logic [7:0]  slice;
	logic        rise0;
	logic        fall0;
	logic        rise1;
	logic        fall1;
	logic [frt_capture_pkg::NUM_CAPTURES-1:0] cap_stb;
	logic [frt_capture_pkg::NUM_CAPTURES-1:0] cap_wr;
	logic [frt_capture_pkg::NUM_CAPTURES-1:0] cap_rd;
	logic [7:0]  cap_val [frt_capture_pkg::NUM_CAPTURES];
	logic [7:0]  cap_reg [frt_capture_pkg::NUM_CAPTURES];
	logic [5:0]  cap_idx [frt_capture_pkg::NUM_CAPTURES];

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	// indices 0x26..0x29 fall in the gap and are refused
	function automatic logic is_mapped(input logic [5:0] idx);
		logic in_block;
		logic in_config;
		in_block  = (idx >= frt_capture_pkg::IDX_COUNTER_LOW)
			&& (idx <= frt_capture_pkg::IDX_CAP1_FALL);
		in_config = (idx == frt_capture_pkg::IDX_TIMER_CONFIG);
		is_mapped = in_block | in_config;
	endfunction : is_mapped

	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	assign awready = ~aw_held_ff & ~bvalid_ff;
	assign wready  = ~w_held_ff & ~bvalid_ff;
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign wr_idx  = awaddr_ff[7:2];
	assign wr_byte = wdata_ff[7:0];
	assign wr_ok   = wr_fire & is_mapped(wr_idx) & wstrb_ff[0];

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign wr_counter_low  = wr_ok & (wr_idx == frt_capture_pkg::IDX_COUNTER_LOW);
	assign wr_counter_high = wr_ok & (wr_idx == frt_capture_pkg::IDX_COUNTER_HIGH);
	assign wr_config       = wr_ok & (wr_idx == frt_capture_pkg::IDX_TIMER_CONFIG);
	assign rd_counter_low  = rd_fire & (rd_idx == frt_capture_pkg::IDX_COUNTER_LOW);
	// lane 0 off still answers okay; only an unmapped index is refused
	assign wr_resp = is_mapped(wr_idx) ? frt_capture_pkg::RESP_OKAY
		: frt_capture_pkg::RESP_SLVERR;
	assign rd_resp = is_mapped(rd_idx) ? frt_capture_pkg::RESP_OKAY
		: frt_capture_pkg::RESP_SLVERR;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= 8'h00;
		end else if (axi_req.awvalid && awready) begin
			aw_held_ff <= 1'b1;
			awaddr_ff  <= axi_req.awaddr;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			w_held_ff <= 1'b0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
		end else if (axi_req.wvalid && wready) begin
			w_held_ff <= 1'b1;
			wdata_ff  <= axi_req.wdata;
			wstrb_ff  <= axi_req.wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= frt_capture_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_resp;
		end else if (axi_req.bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------------------------------
	assign arready = ~rvalid_ff;
	assign rd_fire = axi_req.arvalid & arready;
	assign rd_idx  = axi_req.araddr[7:2];

	always_comb begin
		rd_byte = 8'h00;
		case (rd_idx)
			frt_capture_pkg::IDX_COUNTER_LOW:  rd_byte = counter_ff[7:0];
			frt_capture_pkg::IDX_COUNTER_HIGH: rd_byte = high_rd_hold_ff;
			frt_capture_pkg::IDX_CAP0_RISE:    rd_byte = cap_reg[frt_capture_pkg::CAP0_RISE];
			frt_capture_pkg::IDX_CAP1_RISE:    rd_byte = cap_reg[frt_capture_pkg::CAP1_RISE];
			frt_capture_pkg::IDX_CAP0_FALL:    rd_byte = cap_reg[frt_capture_pkg::CAP0_FALL];
			frt_capture_pkg::IDX_CAP1_FALL:    rd_byte = cap_reg[frt_capture_pkg::CAP1_FALL];
			frt_capture_pkg::IDX_TIMER_CONFIG: rd_byte = config_ff;
			default:                           rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= frt_capture_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h00_0000, rd_byte};
			rresp_ff  <= rd_resp;
		end else if (axi_req.rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = awready;
		axi_rsp.wready  = wready;
		axi_rsp.bvalid  = bvalid_ff;
		axi_rsp.bresp   = bresp_ff;
		axi_rsp.arready = arready;
		axi_rsp.rvalid  = rvalid_ff;
		axi_rsp.rdata   = rdata_ff;
		axi_rsp.rresp   = rresp_ff;
	end

	// ----------------------------------------------------------------
	// timer tick divider
	// ----------------------------------------------------------------
	// timer advances only on its tick, never on bus timing
	assign tick = (div_ff == DIV_LAST);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_ff <= 16'h0000;
		end else if (tick) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// free-running counter and its holding registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			counter_ff <= frt_capture_pkg::COUNTER_RESET;
		end else if (wr_counter_high) begin
			// load beats the tick, so the written value is seen exactly
			counter_ff <= {wr_byte, low_wr_hold_ff};
		end else if (tick) begin
			counter_ff <= counter_ff + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			low_wr_hold_ff <= frt_capture_pkg::BYTE_RESET;
		end else if (wr_counter_low) begin
			low_wr_hold_ff <= wr_byte;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			high_rd_hold_ff <= frt_capture_pkg::BYTE_RESET;
		end else if (rd_counter_low) begin
			// upper byte frozen at the low read keeps the pair coherent
			high_rd_hold_ff <= counter_ff[15:8];
		end
	end

	// ----------------------------------------------------------------
	// timer configuration
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			config_ff <= frt_capture_pkg::CFG_RESET;
		end else if (wr_config) begin
			// reserved bits 2..0 always read zero
			config_ff <= wr_byte & frt_capture_pkg::CFG_WRITE_MASK;
		end
	end

	assign hold_en             = config_ff[frt_capture_pkg::CFG_HOLD_BIT];
	assign wide_capture_enable = config_ff[frt_capture_pkg::CFG_WIDE_BIT];
	assign prescale            = config_ff[frt_capture_pkg::CFG_PRESCALE_MSB:
		frt_capture_pkg::CFG_PRESCALE_LSB];
	assign slice               = 8'(counter_ff >> prescale);

	// ----------------------------------------------------------------
	// capture inputs
	// ----------------------------------------------------------------
	capture_edge_detect u_edge0 (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in (capture_input_0),
		.rise     (rise0),
		.fall     (fall0)
	);

	capture_edge_detect u_edge1 (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in (capture_input_1),
		.rise     (rise1),
		.fall     (fall1)
	);

	// ----------------------------------------------------------------
	// capture steering
	// ----------------------------------------------------------------
	always_comb begin
		cap_stb[frt_capture_pkg::CAP0_RISE] = rise0;
		cap_stb[frt_capture_pkg::CAP0_FALL] = fall0;
		if (wide_capture_enable) begin
			// channel 1 registers extend channel 0; input 1 is ignored
			cap_stb[frt_capture_pkg::CAP1_RISE] = rise0;
			cap_stb[frt_capture_pkg::CAP1_FALL] = fall0;
			cap_val[frt_capture_pkg::CAP0_RISE] = counter_ff[7:0];
			cap_val[frt_capture_pkg::CAP0_FALL] = counter_ff[7:0];
			cap_val[frt_capture_pkg::CAP1_RISE] = counter_ff[15:8];
			cap_val[frt_capture_pkg::CAP1_FALL] = counter_ff[15:8];
		end else begin
			cap_stb[frt_capture_pkg::CAP1_RISE] = rise1;
			cap_stb[frt_capture_pkg::CAP1_FALL] = fall1;
			cap_val[frt_capture_pkg::CAP0_RISE] = slice;
			cap_val[frt_capture_pkg::CAP0_FALL] = slice;
			cap_val[frt_capture_pkg::CAP1_RISE] = slice;
			cap_val[frt_capture_pkg::CAP1_FALL] = slice;
		end
	end

	always_comb begin
		cap_idx[frt_capture_pkg::CAP0_RISE] = frt_capture_pkg::IDX_CAP0_RISE;
		cap_idx[frt_capture_pkg::CAP1_RISE] = frt_capture_pkg::IDX_CAP1_RISE;
		cap_idx[frt_capture_pkg::CAP0_FALL] = frt_capture_pkg::IDX_CAP0_FALL;
		cap_idx[frt_capture_pkg::CAP1_FALL] = frt_capture_pkg::IDX_CAP1_FALL;
	end

	for (genvar g = 0; g < frt_capture_pkg::NUM_CAPTURES; g++) begin : g_cap
		assign cap_wr[g] = wr_ok & (wr_idx == cap_idx[g]);
		assign cap_rd[g] = rd_fire & (rd_idx == cap_idx[g]);

		capture_slot u_slot (
			.core_clk      (core_clk),
			.nrst          (nrst),
			.hold_en       (hold_en),
			.capture_stb   (cap_stb[g]),
			.capture_value (cap_val[g]),
			.wr_stb        (cap_wr[g]),
			.wr_value      (wr_byte),
			.rd_stb        (cap_rd[g]),
			.value_ff      (cap_reg[g])
		);
	end

endmodule : free_running_timer_edge_capture

`default_nettype wire

// file: testbench/frt_capture_monitor.sv
// bus-side assertions for the free-running timer with edge capture
`timescale 1ns/1ps
`default_nettype none

module frt_capture_monitor #(
	parameter int unsigned TICK_DIV = 1
) (
	input wire logic                           core_clk,
	input wire logic                           nrst,
	input wire frt_capture_pkg::axi_lite_req_t axi_req,
	input wire frt_capture_pkg::axi_lite_rsp_t axi_rsp,
	input wire logic                           capture_input_0,
	input wire logic                           capture_input_1
);
	logic [5:0] r_idx;
	logic [5:0] w_idx;
	logic       r_map;
	logic       w_map;

	assign r_idx = axi_req.araddr[7:2];
	assign w_idx = axi_req.awaddr[7:2];
	assign r_map = (r_idx >= 6'h20 && r_idx <= 6'h25) || r_idx == 6'h2A;
	assign w_map = (w_idx >= 6'h20 && w_idx <= 6'h25) || w_idx == 6'h2A;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// handshake steps
	// ----------------------------------------------------------------
	sequence ar_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	sequence w_both;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence

	read_answer_a: assert property (ar_taken |=> axi_rsp.rvalid)
		else $error("read answer missing");
	write_answer_a: assert property (w_both |-> ##2 axi_rsp.bvalid)
		else $error("write answer missing");
	read_once_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
		else $error("read answer repeated");
	read_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read accepted while answer pending");
	write_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write accepted while answer pending");
	byte_data_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	unmapped_read_a: assert property (ar_taken ##0 !r_map |=>
		axi_rsp.rresp == frt_capture_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	mapped_read_a: assert property (ar_taken ##0 r_map |=> axi_rsp.rresp == frt_capture_pkg::RESP_OKAY)
		else $error("mapped read refused");
	unmapped_write_a: assert property (w_both ##0 !w_map |-> ##2
		axi_rsp.bresp == frt_capture_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	cfg_reserved_a: assert property (ar_taken ##0 r_idx == 6'h2A |=> axi_rsp.rdata[2:0] == 3'h0)
		else $error("reserved config bits not zero");
endmodule : frt_capture_monitor

`default_nettype wire

// file: testbench/capture_pulse_source.sv
// pulse source standing in for the two external capture signals
`timescale 1ns/1ps
`default_nettype none

module capture_pulse_source (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic [1:0] fire,
	input  wire logic [7:0] width,
	output logic            pin_0,
	output logic            pin_1
);
	logic [1:0][7:0] cnt_ff;
	logic [1:0]      pin_ff;

	// pin rises at the edge that sees fire, falls width edges later
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_ff <= 2'h0;
			cnt_ff <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (fire[i]) begin
					pin_ff[i] <= 1'b1;
					cnt_ff[i] <= width;
				end else if (cnt_ff[i] != 8'h00) begin
					cnt_ff[i] <= cnt_ff[i] - 8'h01;
					if (cnt_ff[i] == 8'h01) pin_ff[i] <= 1'b0;
				end
			end
		end
	end

	assign pin_0 = pin_ff[0];
	assign pin_1 = pin_ff[1];
endmodule : capture_pulse_source

`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the free-running timer with edge capture
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int          PW = 5;
	localparam logic [15:0] VP = 16'hA5C3;

	logic                           core_clk = 1'b0;
	logic                           nrst = 1'b0;
	logic [1:0]                     fire = 2'h0;
	logic                           cap0;
	logic                           cap1;
	int                             fails = 0;
	int                             checks_done = 0;
	frt_capture_pkg::axi_lite_req_t req;
	frt_capture_pkg::axi_lite_rsp_t rsp;
	logic [31:0]                    rd_d;
	logic [1:0]                     rd_r;
	logic [1:0]                     wr_r;

	always #10 core_clk = ~core_clk;

	free_running_timer_edge_capture #(.TICK_DIV(1)) dut_u (.core_clk(core_clk), .nrst(nrst),
		.axi_req(req), .axi_rsp(rsp), .capture_input_0(cap0), .capture_input_1(cap1));
	capture_pulse_source src_u (.core_clk(core_clk), .nrst(nrst), .fire(fire), .width(8'(PW)),
		.pin_0(cap0), .pin_1(cap1));

	// ----------------------------------------------------------------
	// bus and check helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : chk

	// returns at the edge where bvalid is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.awaddr <= a;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		wr_r = rsp.bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rd_d = rsp.rdata;
		rd_r = rsp.rresp;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(rd_d, {24'h0, e});
	endtask : rdc

	task automatic set_cnt(input logic [15:0] v);
		wr(8'h80, v[7:0]);
		wr(8'h84, v[15:8]);
	endtask : set_cnt

	// edge reaches the capture four edges after fire is set
	task automatic pulse(input logic [1:0] m);
		fire <= m;
		@(posedge core_clk);
		fire <= 2'h0;
		repeat (12) @(posedge core_clk);
	endtask : pulse

	function automatic logic [7:0] sl(input logic [15:0] v, input int p);
		return 8'(v >> p);
	endfunction : sl

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] a [6] = '{8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'hA8};
		foreach (a[i]) rdc(a[i], 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_counter;
		set_cnt(16'hFFFD);
		rdc(8'h80, 8'hFE);
		repeat (3) @(posedge core_clk);
		rdc(8'h84, 8'hFF);
		rd(8'h80);
		rdc(8'h84, 8'h00);
		$display("test counter done");
	endtask : t_counter

	task automatic t_prescale;
		for (int p = 0; p < 8; p++) begin
			wr(8'hA8, 8'(p << 4));
			set_cnt(VP);
			pulse(2'h3);
			rdc(8'h88, sl(VP + 16'd4, p));
			rdc(8'h8C, sl(VP + 16'd4, p));
			rdc(8'h90, sl(VP + 16'd4 + 16'(PW), p));
		end
		$display("test prescale done");
	endtask : t_prescale

	task automatic t_wide;
		wr(8'hA8, 8'h08);
		set_cnt(16'h7EFC);
		pulse(2'h3);
		rdc(8'h88, 8'h00);
		rdc(8'h8C, 8'h7F);
		rdc(8'h90, 8'h05);
		rdc(8'h94, 8'h7F);
		$display("test wide done");
	endtask : t_wide

	task automatic t_hold;
		wr(8'hA8, 8'h80);
		set_cnt(16'h0100);
		pulse(2'h1);
		pulse(2'h1);
		rdc(8'h88, 8'h04);
		rdc(8'h90, 8'h09);
		set_cnt(16'h0230);
		pulse(2'h1);
		rdc(8'h88, 8'h34);
		$display("test hold done");
	endtask : t_hold

	task automatic t_bus;
		wr(8'hA8, 8'hFF);
		rdc(8'hA8, 8'hF8);
		wr(8'hA8, 8'h00);
		wr(8'h88, 8'h3C);
		rdc(8'h88, 8'h3C);
		wr(8'hFC, 8'h5A);
		chk(32'(wr_r), 32'(frt_capture_pkg::RESP_SLVERR));
		rd(8'hFC);
		chk(32'(rd_r), 32'(frt_capture_pkg::RESP_SLVERR));
		chk(rd_d, 32'h0);
		$display("test bus done");
	endtask : t_bus

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_counter();
		t_prescale();
		t_wide();
		t_hold();
		t_bus();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		summarize();
	end
endmodule : tb_top

bind free_running_timer_edge_capture frt_capture_monitor #(.TICK_DIV(TICK_DIV)) mon_u (
	.core_clk(core_clk), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.capture_input_0(capture_input_0), .capture_input_1(capture_input_1));

`default_nettype wire
